// File: rtcfd_top.sv
// rtcfd_top: control, interrupt flag and validity registers on the multiplexed bus
// assumes: bus pins, power sense and reset pin are asynchronous; event inputs share mclk_i
//
// Summary of operation
// - hour-format bit, 1 = 24-hour, 0 = 12-hour; changed only by software.
// - summer time on: last April Sunday, 1:59:59 AM jumps to 3:00:00 AM.
// - summer time on: last October Sunday, first 1:59:59 AM returns to 1:00:00.
// - summer time off blocks both jumps; reset never alters the enable.
// - pending flag bit 7 is OR of each flag ANDed with its enable.
// - interrupt request pin held low exactly while pending flag is 1.
// - all flags clear after the flag register is read and while reset pin low.
// - periodic flag bit 6 set on each selected divider edge, regardless of enable.
// - alarm flag bit 5 set when current time matches the alarm time.
// - update flag bit 4 set at the end of every update cycle.
// - flag register is read-only; bits 3 to 0 read as zero.
// - valid bit 7 forced to 0 while power sense is low.
// - valid bit set only by reading the validity register; reset pin ignores it.
// - validity register bits 6 to 0 read zero and ignore writes.
// - update enable cleared by reset pin low and by the inhibit bit rising.
// - alarm enable cleared to 0 by reset pin, untouched by internal functions.
`timescale 1ns/100ps
module rtcfd_top
    import rtcfd_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire rtcfd_pins_t pins_i,
    input  wire logic        periodic_evt_i,
    input  wire logic        alarm_match_i,
    input  wire logic        update_done_i,
    input  wire logic        update_tick_i,
    input  wire rtcfd_time_t now_i,
    output logic       [7:0] ad_o,
    output logic             ad_oe_o,
    output logic             irq_n_o,
    output logic             hour_24_o,
    output logic             summer_time_en_o,
    output logic             update_inhibit_o,
    output logic             sqw_en_o,
    output logic             binary_mode_o,
    output logic             spring_fwd_o,
    output logic             fall_back_o
);
    // three-stage pin synchroniser; s1 feeds only s2, a change counts when s2 and s3 agree
    rtcfd_pins_t s1_r, s2_r, s3_r, filt_r, filt_nxt, prev_r;

    always_comb begin
        filt_nxt = filt_r;
        if (s2_r == s3_r) begin
            filt_nxt = s3_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
            prev_r <= '0;
        end else begin
            s1_r   <= pins_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    // strobe edges seen on the filtered pins
    logic astb_fall, dstb_rise, dstb_fall, rst_pin_low, power_ok;
    assign astb_fall   = prev_r.address_strobe && !filt_r.address_strobe;
    assign dstb_rise   = !prev_r.data_strobe && filt_r.data_strobe;
    assign dstb_fall   = prev_r.data_strobe && !filt_r.data_strobe;
    assign rst_pin_low = !filt_r.reset_pin_n;
    assign power_ok    = filt_r.power_sense_pin;

    // register state
    logic [7:0] addr_r, addr_nxt;
    logic       sel_r, sel_nxt;
    logic       rd_act_r, rd_act_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic       valid_r, valid_nxt;
    logic       irq_n_r, irq_n_nxt;
    logic [2:0] en_now, en_nxt, evt;
    logic       pend_now, pend_nxt;
    logic       rd_start, rd_end, wr_end, wr_ctrl, rd_flags_end, rd_valid_start;
    logic [7:0] wr_val;

    assign en_now   = {ctrl_r[RTCFD_B_PER_EN], ctrl_r[RTCFD_B_ALM_EN], ctrl_r[RTCFD_B_UPD_EN]};
    assign pend_now = |(flags_r & en_now);
    assign evt      = {periodic_evt_i, alarm_match_i, update_done_i};

    assign rd_start       = dstb_rise && sel_r && filt_r.read_not_write;
    assign rd_end         = dstb_fall && sel_r && rd_act_r;
    assign wr_end         = dstb_fall && sel_r && !filt_r.read_not_write && !rd_act_r;
    assign wr_ctrl        = wr_end && (addr_r == RTCFD_OFS_CTRL);
    assign rd_flags_end   = rd_end && (addr_r == RTCFD_OFS_FLAGS);
    assign rd_valid_start = rd_start && (addr_r == RTCFD_OFS_VALID);
    assign wr_val         = filt_r.ad;

    // bus cycle: address on strobe fall, read data snapshot on data strobe rise,
    // write data on its fall; only the control register accepts writes
    always_comb begin
        addr_nxt   = addr_r;
        sel_nxt    = sel_r;
        rd_act_nxt = rd_act_r;
        rdata_nxt  = rdata_r;
        ctrl_nxt   = ctrl_r;
        if (astb_fall) begin
            addr_nxt = filt_r.ad;
            sel_nxt  = !filt_r.chip_sel_n;
        end
        if (rd_start) begin
            rd_act_nxt = 1'b1;
            unique case (addr_r)
                RTCFD_OFS_CTRL:  rdata_nxt = ctrl_r;
                RTCFD_OFS_FLAGS: rdata_nxt = {pend_now, flags_r, RTCFD_LOW_NIBBLE};
                RTCFD_OFS_VALID: rdata_nxt = {valid_r, RTCFD_VALID_PAD};
                default:         rdata_nxt = RTCFD_ZERO_BYTE;
            endcase
        end
        if (rd_end) begin
            rd_act_nxt = 1'b0;
        end
        if (wr_ctrl) begin
            ctrl_nxt = wr_val;
            if (wr_val[RTCFD_B_SET] && !ctrl_r[RTCFD_B_SET]) begin
                ctrl_nxt[RTCFD_B_UPD_EN] = 1'b0;
            end
        end
        // reset pin clears enables and square wave, never format, mode or summer time
        if (rst_pin_low) begin
            ctrl_nxt[RTCFD_B_PER_EN] = 1'b0;
            ctrl_nxt[RTCFD_B_ALM_EN] = 1'b0;
            ctrl_nxt[RTCFD_B_UPD_EN] = 1'b0;
            ctrl_nxt[RTCFD_B_SQWE] = 1'b0;
        end
    end

    // flags: a set in the clearing cycle wins, so an event in that cycle is not dropped by the read
    always_comb begin
        flags_nxt = flags_r;
        if (rd_flags_end) begin
            flags_nxt = RTCFD_FLAGS_CLEAR;
        end
        flags_nxt = flags_nxt | evt;
        if (rst_pin_low) begin
            flags_nxt = RTCFD_FLAGS_CLEAR;
        end
        en_nxt    = {ctrl_nxt[RTCFD_B_PER_EN], ctrl_nxt[RTCFD_B_ALM_EN],
                     ctrl_nxt[RTCFD_B_UPD_EN]};
        pend_nxt  = |(flags_nxt & en_nxt);
        irq_n_nxt = !pend_nxt;
        valid_nxt = valid_r | rd_valid_start;
        if (!power_ok) begin
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            addr_r   <= RTCFD_ZERO_BYTE;
            sel_r    <= 1'b0;
            rd_act_r <= 1'b0;
            rdata_r  <= RTCFD_ZERO_BYTE;
            ctrl_r   <= RTCFD_ZERO_BYTE;
            flags_r  <= RTCFD_FLAGS_CLEAR;
            valid_r  <= 1'b0;
            irq_n_r  <= 1'b1;
        end else begin
            addr_r   <= addr_nxt;
            sel_r    <= sel_nxt;
            rd_act_r <= rd_act_nxt;
            rdata_r  <= rdata_nxt;
            ctrl_r   <= ctrl_nxt;
            flags_r  <= flags_nxt;
            valid_r  <= valid_nxt;
            irq_n_r  <= irq_n_nxt;
        end
    end

    // bus drives only during a read; the snapshot stays fixed so a clear cannot tear it
    assign ad_o             = rdata_r;
    assign ad_oe_o          = rd_act_r;
    assign irq_n_o          = irq_n_r;
    assign hour_24_o        = ctrl_r[RTCFD_B_HR24];
    assign summer_time_en_o = ctrl_r[RTCFD_B_SUMMER];
    assign update_inhibit_o = ctrl_r[RTCFD_B_SET];
    assign sqw_en_o         = ctrl_r[RTCFD_B_SQWE];
    assign binary_mode_o    = ctrl_r[RTCFD_B_DM];

    rtcfd_dst u_dst (
        .mclk_i           (mclk_i),
        .sys_rst_i        (sys_rst_i),
        .update_tick_i    (update_tick_i),
        .summer_time_en_i (ctrl_r[RTCFD_B_SUMMER]),
        .now_i            (now_i),
        .spring_fwd_o     (spring_fwd_o),
        .fall_back_o      (fall_back_o)
    );

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    a_irq_pin_follow: assert property (irq_n_o == !pend_now)
        else $error("irq pin disagrees with pending flag");
    a_per_flag_set: assert property (periodic_evt_i && !rst_pin_low |=> flags_r[RTCFD_E_PER])
        else $error("periodic flag not set");
    a_alarm_flag_set: assert property (alarm_match_i && !rst_pin_low |=> flags_r[RTCFD_E_ALM])
        else $error("alarm flag not set");
    a_upd_flag_set: assert property (update_done_i && !rst_pin_low |=> flags_r[RTCFD_E_UPD])
        else $error("update flag not set");
    a_read_clears_flags: assert property (rd_flags_end && evt == RTCFD_FLAGS_CLEAR
        |=> flags_r == RTCFD_FLAGS_CLEAR && irq_n_o)
        else $error("flag read did not clear");
    a_pin_clears_all: assert property (rst_pin_low |=> flags_r == RTCFD_FLAGS_CLEAR
        && !ctrl_r[RTCFD_B_ALM_EN] && !ctrl_r[RTCFD_B_UPD_EN])
        else $error("reset pin left flags or enables");
    a_flag_low_nibble: assert property (rd_start && addr_r == RTCFD_OFS_FLAGS
        |=> rdata_r[3:0] == RTCFD_LOW_NIBBLE && rdata_r[RTCFD_B_PEND] == $past(pend_now))
        else $error("flag read data wrong");
    a_valid_forced_low: assert property (!power_ok |=> !valid_r)
        else $error("valid bit set while power low");
    a_valid_only_read: assert property ($rose(valid_r) |-> $past(rd_valid_start))
        else $error("valid bit rose without a read");
    a_valid_pad_zero: assert property (rd_valid_start |=> rdata_r[6:0] == RTCFD_VALID_PAD)
        else $error("validity pad bits not zero");
    a_format_sw_only: assert property (!wr_ctrl |=> $stable(hour_24_o) && $stable(summer_time_en_o))
        else $error("format or summer bit changed without write");
    a_inhibit_drops_en: assert property ($rose(update_inhibit_o) |-> !ctrl_r[RTCFD_B_UPD_EN])
        else $error("update enable survived inhibit");
    a_no_jump_off: assert property (!summer_time_en_o |=> !spring_fwd_o && !fall_back_o)
        else $error("summer-time jump while disabled");

    c_flag_read: cover property (rd_flags_end && pend_now);
    c_event_on_clear: cover property (rd_flags_end && evt != RTCFD_FLAGS_CLEAR);
    c_valid_set: cover property ($rose(valid_r));
    c_fall_back: cover property (fall_back_o);
endmodule // rtcfd_top

// File: rtcfd_pkg.sv
// rtcfd_pkg: constants and carrier types for the clock flag, format and summer-time block
// assumes: time fields arrive in binary from the calendar counters; bus pins are asynchronous
package rtcfd_pkg;

    // register offsets on the multiplexed bus
    localparam logic [7:0] RTCFD_OFS_CTRL  = 8'h0B;
    localparam logic [7:0] RTCFD_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] RTCFD_OFS_VALID = 8'h0D;

    // control register field positions
    localparam int RTCFD_B_SET   = 7;
    localparam int RTCFD_B_PER_EN = 6;
    localparam int RTCFD_B_ALM_EN = 5;
    localparam int RTCFD_B_UPD_EN = 4;
    localparam int RTCFD_B_SQWE   = 3;
    localparam int RTCFD_B_DM     = 2;
    localparam int RTCFD_B_HR24   = 1;
    localparam int RTCFD_B_SUMMER = 0;

    // flag and validity register field positions
    localparam int RTCFD_B_PEND  = 7;
    localparam int RTCFD_B_PER   = 6;
    localparam int RTCFD_B_ALM   = 5;
    localparam int RTCFD_B_UPD   = 4;
    localparam int RTCFD_B_VALID = 7;

    // index of each event inside the three-bit flag and enable vectors
    localparam int RTCFD_E_PER = 2;
    localparam int RTCFD_E_ALM = 1;
    localparam int RTCFD_E_UPD = 0;

    localparam logic [7:0] RTCFD_ZERO_BYTE   = 8'h00;
    localparam logic [2:0] RTCFD_FLAGS_CLEAR = 3'h0;
    localparam logic [3:0] RTCFD_LOW_NIBBLE  = 4'h0;
    localparam logic [6:0] RTCFD_VALID_PAD   = 7'h00;

    // summer-time calendar points (binary time values)
    localparam logic [7:0] RTCFD_MONTH_SPRING = 8'h04;
    localparam logic [7:0] RTCFD_MONTH_FALL   = 8'h0A;
    localparam logic [7:0] RTCFD_SUNDAY       = 8'h01;
    localparam logic [7:0] RTCFD_LAST_WK_APR  = 8'h18;  // 30-day month: last Sunday >= 24
    localparam logic [7:0] RTCFD_LAST_WK_OCT  = 8'h19;  // 31-day month: last Sunday >= 25
    localparam logic [7:0] RTCFD_HOUR_ONE_AM  = 8'h01;
    localparam logic [7:0] RTCFD_MINSEC_LAST  = 8'h3B;

    // pins as they arrive, before synchronising
    typedef struct packed {
        logic       address_strobe;
        logic       data_strobe;
        logic       read_not_write;
        logic       chip_sel_n;
        logic       power_sense_pin;
        logic       reset_pin_n;
        logic [7:0] ad;
    } rtcfd_pins_t;

    // current time and date from the counters
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day_of_week;
    } rtcfd_time_t;

endpackage

// File: rtcfd_dst.sv
// rtcfd_dst: decides the two summer-time jumps at the second boundary
// assumes: update_tick_i pulses once per second while the time shows the second about to end
`timescale 1ns/100ps
module rtcfd_dst
    import rtcfd_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        update_tick_i,
    input  wire logic        summer_time_en_i,
    input  wire rtcfd_time_t now_i,
    output logic             spring_fwd_o,
    output logic             fall_back_o
);
    logic spring_fwd_r, spring_fwd_nxt;
    logic fall_back_r, fall_back_nxt;
    logic fall_done_r, fall_done_nxt;
    logic at_last_second, spring_day, fall_day;

    // hour compare ignores the pm bit pattern only because 1 am is 8'h01 in both formats
    assign at_last_second = (now_i.hour == RTCFD_HOUR_ONE_AM) &&
                            (now_i.minute == RTCFD_MINSEC_LAST) &&
                            (now_i.second == RTCFD_MINSEC_LAST);
    assign spring_day = (now_i.month == RTCFD_MONTH_SPRING) &&
                        (now_i.day_of_week == RTCFD_SUNDAY) &&
                        (now_i.date >= RTCFD_LAST_WK_APR);
    assign fall_day   = (now_i.month == RTCFD_MONTH_FALL) &&
                        (now_i.day_of_week == RTCFD_SUNDAY) &&
                        (now_i.date >= RTCFD_LAST_WK_OCT);

    // the done mark stops a second fall-back when 1:59:59 comes round again that day
    always_comb begin
        spring_fwd_nxt = 1'b0;
        fall_back_nxt  = 1'b0;
        fall_done_nxt  = fall_done_r;
        if (update_tick_i) begin
            if (!fall_day) begin
                fall_done_nxt = 1'b0;
            end
            if (summer_time_en_i && at_last_second) begin
                spring_fwd_nxt = spring_day;
                if (fall_day && !fall_done_r) begin
                    fall_back_nxt = 1'b1;
                    fall_done_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            spring_fwd_r <= 1'b0;
            fall_back_r  <= 1'b0;
            fall_done_r  <= 1'b0;
        end else begin
            spring_fwd_r <= spring_fwd_nxt;
            fall_back_r  <= fall_back_nxt;
            fall_done_r  <= fall_done_nxt;
        end
    end

    assign spring_fwd_o = spring_fwd_r;
    assign fall_back_o  = fall_back_r;
endmodule // rtcfd_dst

// File: rtcfd_host.sv
// rtcfd_host: microprocessor model on the multiplexed address/data bus
// assumes: device answers on ad_o/ad_oe_o; strobes pass a three-flop synchroniser
`timescale 1ns/100ps
module rtcfd_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] dev_ad_i,
    input  wire logic       dev_oe_i,
    output logic            astb_o,
    output logic            dstb_o,
    output logic            rnw_o,
    output logic            cs_n_o,
    output logic      [7:0] ad_o
);
    int hangs = 0;

    // idle bus: both strobes low, not selected
    initial begin
        astb_o = 1'b0;
        dstb_o = 1'b0;
        rnw_o  = 1'b1;
        cs_n_o = 1'b1;
        ad_o   = 8'h00;
    end

    // each strobe level lasts at least five edges so the synchroniser sees it with margin
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // address byte on the first strobe, data byte on the second
    task automatic access(input logic [7:0] addr, input logic rd, input logic [7:0] wd,
                          input logic sel, output logic [7:0] rdat);
        int k;
        rdat = 8'h00;
        k = 0;
        cs_n_o = ~sel;
        ad_o = addr;
        astb_o = 1'b1;
        step(5);
        astb_o = 1'b0;
        step(5);
        rnw_o = rd;
        ad_o = rd ? ~addr : wd;
        dstb_o = 1'b1;
        if (rd) begin
            // look just after the edge so the registered answer has settled
            do begin
                step(1);
                k++;
            end while (dev_oe_i !== 1'b1 && k < 20);
            rdat = dev_ad_i;
            if (dev_oe_i !== 1'b1) hangs++;
            step(3);
        end else begin
            step(5);
        end
        dstb_o = 1'b0;
        step(5);
        ad_o = ~ad_o; // a released bus must not keep showing the last byte
        cs_n_o = 1'b1;
        rnw_o = 1'b1;
        step(2);
    endtask
endmodule // rtcfd_host

// File: tb_rtc_flags_format_dst_control.sv
// tb_rtc_flags_format_dst_control: self-checking bench with an integer register model
// assumes: rtcfd_top ports as declared; host model drives the strobes
`timescale 1ns/100ps
module tb_rtc_flags_format_dst_control
    import rtcfd_pkg::*;
;
    logic        mclk_i, sys_rst_i, pevt, aevt, uevt, tick, pwr, rpin_n;
    logic        dev_oe, irq_n, h24, sum_en, inh, sqw, dm, spr, fb;
    logic        h_astb, h_dstb, h_rnw, h_cs;
    logic  [7:0] dev_ad, h_ad, d, v;
    rtcfd_time_t now;
    rtcfd_pins_t pins;
    int          errors = 0, samples_checked = 0, seed = 64;
    int          ctrl_m = 0, fl_m = 0, val_m = 0, spr_m = 0, fb_m = 0, spr_n = 0, fb_n = 0;
    logic [31:0] cases [7] = '{32'h041C0100, 32'h0A1D0100, 32'h041C0190, 32'h041C0280,
                               32'h04170180, 32'h0A1D0181, 32'h0A1D0180};

    // shared bus: device wins while it drives
    assign pins = {h_astb, h_dstb, h_rnw, h_cs, pwr, rpin_n, dev_oe ? dev_ad : h_ad};

    rtcfd_host u_host (.mclk_i(mclk_i), .dev_ad_i(dev_ad), .dev_oe_i(dev_oe), .astb_o(h_astb),
        .dstb_o(h_dstb), .rnw_o(h_rnw), .cs_n_o(h_cs), .ad_o(h_ad));

    rtcfd_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
        .periodic_evt_i(pevt), .alarm_match_i(aevt), .update_done_i(uevt),
        .update_tick_i(tick), .now_i(now), .ad_o(dev_ad), .ad_oe_o(dev_oe), .irq_n_o(irq_n),
        .hour_24_o(h24), .summer_time_en_o(sum_en), .update_inhibit_o(inh), .sqw_en_o(sqw),
        .binary_mode_o(dm), .spring_fwd_o(spr), .fall_back_o(fb));

    // clock and jump-pulse counters
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        spr_n <= spr_n + (spr === 1'b1);
        fb_n  <= fb_n + (fb === 1'b1);
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        errors += u_host.hangs;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        u_host.access(a, 1'b1, 8'h00, 1'b1, q);
    endtask

    // control write; a rising inhibit bit drops the update enable
    task automatic wctrl(input logic [7:0] w, input logic sel);
        logic [7:0] q;
        u_host.access(RTCFD_OFS_CTRL, 1'b0, w, sel, q);
        if (sel && w[7] && !ctrl_m[7]) w[4] = 1'b0;
        if (sel) ctrl_m = w;
    endtask

    task automatic pulse(input logic [2:0] e);
        {pevt, aevt, uevt} = e;
        fl_m |= e;
        cyc(1);
        {pevt, aevt, uevt} = 3'h0;
        cyc(2);
    endtask

    function automatic logic [7:0] flags_exp();
        logic [2:0] f;
        f = fl_m[2:0];
        return {|(f & {ctrl_m[6], ctrl_m[5], ctrl_m[4]}), f, 4'h0};
    endfunction

    // control register and its level outputs
    task automatic chk_ctrl;
        logic [7:0] q;
        rd(RTCFD_OFS_CTRL, q);
        check("ctrl", ctrl_m[7:0], q);
        check("ctrl pins", {3'h0, ctrl_m[7], ctrl_m[3:0]}, {3'h0, inh, sqw, dm, h24, sum_en});
    endtask

    task automatic chk_flags;
        logic [7:0] q, e;
        e = flags_exp();
        check("irq", {7'h00, ~e[7]}, {7'h00, irq_n});
        rd(RTCFD_OFS_FLAGS, q);
        check("flags", flags_exp(), q);
        fl_m = 0;
        check("irq after read", 8'h01, {7'h00, irq_n});
    endtask

    initial begin
        {pevt, aevt, uevt, tick} = 4'h0;
        pwr = 1'b1;
        rpin_n = 1'b1;
        now = '0;
        sys_rst_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        cyc(4);
        chk_ctrl();
        chk_flags();
        $display("test reset state done");
        // random control values with inhibit low, a deselected write, then inhibit rising
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            wctrl({1'b0, v[6:0]}, 1'b1);
            chk_ctrl();
        end
        wctrl(8'hFF, 1'b0);
        chk_ctrl();
        wctrl(8'h10, 1'b1);
        wctrl(8'h90, 1'b1);
        chk_ctrl();
        $display("test control done");
        // every enable mix against random events
        for (int en = 0; en < 8; en++) begin
            v = $random(seed);
            wctrl({1'b0, en[2:0], 4'h0}, 1'b1);
            pulse(v[2:0]);
            chk_flags();
            rd(RTCFD_OFS_FLAGS, d);
            check("flags cleared", 8'h00, d);
        end
        $display("test flags done");
        // read-only places and an unmapped address
        pulse(3'h7);
        u_host.access(RTCFD_OFS_FLAGS, 1'b0, 8'hFF, 1'b1, d);
        u_host.access(RTCFD_OFS_VALID, 1'b0, 8'hFF, 1'b1, d);
        chk_flags();
        rd(RTCFD_OFS_VALID, d);
        check("valid", val_m[7:0], d);
        val_m = 8'h80;
        rd(RTCFD_OFS_VALID, d);
        check("valid set", val_m[7:0], d);
        rd(8'h3F, d);
        check("unmapped", 8'h00, d);
        pwr = 1'b0;
        cyc(6);
        val_m = 0;
        rd(RTCFD_OFS_VALID, d);
        rd(RTCFD_OFS_VALID, d);
        check("valid power low", 8'h00, d);
        pwr = 1'b1;
        cyc(6);
        rd(RTCFD_OFS_VALID, d);
        val_m = 8'h80;
        $display("test validity done");
        // device reset pin keeps format, mode, summer time and validity; inhibit stays low throughout
        wctrl(8'h7F, 1'b1);
        pulse(3'h7);
        rpin_n = 1'b0;
        cyc(8);
        rpin_n = 1'b1;
        cyc(6);
        ctrl_m &= 8'h87;
        fl_m = 0;
        chk_ctrl();
        chk_flags();
        rd(RTCFD_OFS_VALID, d);
        check("valid kept", val_m[7:0], d);
        $display("test reset pin done");
        // summer-time jumps at 1:59:59 AM
        for (int i = 0; i < 7; i++) begin
            wctrl({7'h00, cases[i][7]}, 1'b1);
            now = {8'h01, 8'h3B, 8'h3B, cases[i][31:8]};
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            cyc(3);
            spr_m += cases[i][4];
            fb_m += cases[i][0];
            check("spring count", spr_m[7:0], spr_n[7:0]);
            check("fall count", fb_m[7:0], fb_n[7:0]);
        end
        $display("test summer time done");
        summarize();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge mclk_i);
        errors++;
        summarize();
    end
endmodule // tb_rtc_flags_format_dst_control
